// [core/ecs_top.sv]
// Configuration ports and per-channel link status outputs of the Ethernet core
`include "ecs_consts.svh"
`default_nettype none

module ecs_top
    import ecs_pkg::*;
#(
    parameter int           NL        = 4,
    parameter bit           IS_100G   = 1'b0,
    parameter bit           PTP_COMBO = 1'b0,
    parameter int           NTS       = 1,
    parameter ecs_lf_mode_t LF_MODE   = ECS_LF_BIDIR,
    parameter int           INIT_CYC  = `ECS_INIT_CYC
)
(
    // Clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst,
    // Serdes configuration ports, one per lane
    input  wire logic [NL*`ECS_SD_AW-1:0] i_sd_addr,
    input  wire logic [NL-1:0]            i_sd_write,
    input  wire logic [NL-1:0]            i_sd_read,
    input  wire logic [NL*`ECS_DW-1:0]    i_sd_wdata,
    output logic      [NL*`ECS_DW-1:0]    o_sd_rdata,
    output logic      [NL-1:0]            o_sd_waitreq,
    // FEC configuration ports, one per channel
    input  wire logic [NL*`ECS_FEC_AW-1:0] i_fec_addr,
    input  wire logic [NL-1:0]            i_fec_write,
    input  wire logic [NL-1:0]            i_fec_read,
    input  wire logic [NL*`ECS_DW-1:0]    i_fec_wdata,
    output logic      [NL*`ECS_DW-1:0]    o_fec_rdata,
    output logic      [NL-1:0]            o_fec_waitreq,
    // Timestamp bridge configuration ports
    input  wire logic [NTS*`ECS_TS_AW-1:0] i_ts_addr,
    input  wire logic [NTS-1:0]           i_ts_write,
    input  wire logic [NTS-1:0]           i_ts_read,
    input  wire logic [NTS*`ECS_DW-1:0]   i_ts_wdata,
    output logic      [NTS*`ECS_DW-1:0]   o_ts_rdata,
    output logic      [NTS-1:0]           o_ts_waitreq,
    // Raw lane and channel conditions, asynchronous
    input  wire logic [NL-1:0]            i_lane_cdr_lock,
    input  wire logic [NL-1:0]            i_lane_tx_ok,
    input  wire logic [NL-1:0]            i_lane_blk_lock,
    input  wire logic                     i_vlane_deskewed,
    input  wire logic [NL-1:0]            i_rx_pcs_fault,
    input  wire logic [NL-1:0]            i_rx_remote_os,
    input  wire logic [NL-1:0]            i_rx_ber_alarm,
    input  wire logic                     i_hard_rst_n,
    input  wire logic [NL-1:0]            i_tx_rst_n,
    input  wire logic [NL-1:0]            i_rx_rst_n,
    input  wire logic [NL-1:0]            i_tx_soft_rst,
    input  wire logic [NL-1:0]            i_rx_soft_rst,
    // Statistics snapshot, same clock
    input  wire logic [NL-1:0]            i_stats_snapshot,
    // Status outputs
    output logic      [NL-1:0]            o_rx_clk_locked,
    output logic      [NL-1:0]            o_tx_lanes_stable,
    output logic      [NL-1:0]            o_rx_block_lock,
    output logic      [NL-1:0]            o_rx_marker_aligned,
    output logic      [NL-1:0]            o_rx_ready,
    output logic      [NL-1:0]            o_local_fault,
    output logic      [NL-1:0]            o_remote_fault,
    output logic      [NL-1:0]            o_rx_high_error_rate,
    output logic      [NL-1:0]            o_core_ready,
    output logic      [NL*`ECS_WORD_W-1:0] o_tx_counter_status,
    output logic      [NL-1:0]            o_rx_shadow_on
);

    localparam int SW = 10 * NL + 2;
    localparam int CW = $clog2(INIT_CYC + 1);
    localparam int WW = `ECS_WORD_W;
    localparam int DW = `ECS_DW;
    localparam int SA = `ECS_SD_AW;
    localparam int FA = `ECS_FEC_AW;
    localparam int TA = `ECS_TS_AW;

    if (NL < 1 || NL > 4 || (IS_100G && NL != 4) || NTS < 1 || INIT_CYC < 1)
    begin : g_bad
        $error("ecs_top: unsupported parameters");
    end

    typedef struct packed {
        logic [SW-1:0]          s1;
        logic [SW-1:0]          s2;
        logic                   regs_clr;
        logic [NL-1:0]          cdr;
        logic [NL-1:0]          txs;
        logic [NL-1:0]          blk;
        logic [NL-1:0]          am;
        logic [NL-1:0]          rdy;
        logic [NL-1:0]          lf;
        logic [NL-1:0]          rf;
        logic [NL-1:0]          ber;
        logic [NL-1:0]          core;
        logic [NL-1:0]          snap_q;
        logic [NL-1:0]          tx_sh;
        logic [NL-1:0]          rx_sh;
        logic [NL-1:0][CW-1:0]  icnt;
    } ecs_top_state_t;

    ecs_top_state_t r_reg;
    ecs_top_state_t r_next;

    logic [NL-1:0] cdr_s;
    logic [NL-1:0] txok_s;
    logic [NL-1:0] blk_s;
    logic [NL-1:0] pcsf_s;
    logic [NL-1:0] rem_s;
    logic [NL-1:0] ber_s;
    logic [NL-1:0] txrst_n_s;
    logic [NL-1:0] rxrst_n_s;
    logic [NL-1:0] txsoft_s;
    logic [NL-1:0] rxsoft_s;
    logic          desk_s;
    logic          hard_n_s;

    // Only the second stage feeds any logic
    assign {cdr_s, txok_s, blk_s, pcsf_s, rem_s, ber_s,
            txrst_n_s, rxrst_n_s, txsoft_s, rxsoft_s, desk_s, hard_n_s} = r_reg.s2;

    // In 100G mode channel 0 owns all lanes; the others stay idle
    function automatic logic agg(input logic [NL-1:0] v, input int c);
        logic res;
        res = v[c];
        if (IS_100G)
            res = (c == 0) ? &v : 1'b0;
        return res;
    endfunction

    // ----------------------------------------
    // Status and snapshot logic
    // ----------------------------------------
    always_comb
    begin
        logic act;
        logic tx_dn;
        logic rx_dn;
        act    = 1'b0;
        tx_dn  = 1'b0;
        rx_dn  = 1'b0;
        r_next = r_reg;
        r_next.s1 = {i_lane_cdr_lock, i_lane_tx_ok, i_lane_blk_lock, i_rx_pcs_fault,
                     i_rx_remote_os, i_rx_ber_alarm, i_tx_rst_n, i_rx_rst_n,
                     i_tx_soft_rst, i_rx_soft_rst, i_vlane_deskewed, i_hard_rst_n};
        r_next.s2       = r_reg.s1;
        r_next.regs_clr = ~hard_n_s;
        r_next.snap_q   = i_stats_snapshot;
        r_next.cdr      = cdr_s;                                            // R10
        for (int c = 0; c < NL; c++)
        begin
            act   = !IS_100G || (c == 0);
            tx_dn = !hard_n_s || !txrst_n_s[c];
            rx_dn = !hard_n_s || !rxrst_n_s[c];
            r_next.txs[c] = act && !tx_dn && agg(txok_s, c);                // R11
            r_next.blk[c] = act && !rx_dn && agg(blk_s, c);                 // R12
            r_next.am[c]  = IS_100G && (c == 0) && !rx_dn && (&blk_s) && desk_s; // R13
            r_next.rdy[c] = r_next.blk[c] && (IS_100G ? r_next.am[c] : 1'b1);   // R14
            r_next.lf[c]  = act && !rx_dn && (LF_MODE != ECS_LF_OFF) && pcsf_s[c]; // R15
            r_next.rf[c]  = act && !rx_dn && (LF_MODE == ECS_LF_BIDIR) && rem_s[c]; // R16
            r_next.ber[c] = act && !rx_dn && ber_s[c];                      // R20
            // Ready waits out a full initialisation after the last reset other than a receive hard reset
            if (tx_dn || txsoft_s[c] || rxsoft_s[c] || !act)
            begin
                r_next.icnt[c] = CW'(INIT_CYC);                             // R21
                r_next.core[c] = 1'b0;                                      // R22
            end
            else if (r_reg.icnt[c] != '0)
                r_next.icnt[c] = r_reg.icnt[c] - 1'b1;
            else
                r_next.core[c] = 1'b1;                                      // R21
            // Snapshot is already on this clock, so no synchroniser
            if (i_stats_snapshot[c] && !r_reg.snap_q[c])
            begin
                r_next.tx_sh[c] = 1'b1;                                     // R17 R19
                r_next.rx_sh[c] = 1'b1;
            end
            else if (!i_stats_snapshot[c] && r_reg.snap_q[c])
            begin
                r_next.tx_sh[c] = 1'b0;                                     // R17
                r_next.rx_sh[c] = 1'b0;
            end
        end
        // Synchronisers keep running, so a port reset never looks like a hard reset and wipes storage
        if (i_rst)
        begin
            r_next = '{s1: r_next.s1, s2: r_next.s2, icnt: {NL{CW'(INIT_CYC)}}, default: '0}; // R24
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        r_reg <= r_next;
    end

    assign o_rx_clk_locked      = r_reg.cdr;
    assign o_tx_lanes_stable    = r_reg.txs;
    assign o_rx_block_lock      = r_reg.blk;
    assign o_rx_marker_aligned  = r_reg.am;
    assign o_rx_ready           = r_reg.rdy;
    assign o_local_fault        = r_reg.lf;
    assign o_remote_fault       = r_reg.rf;
    assign o_rx_high_error_rate = r_reg.ber;
    assign o_core_ready         = r_reg.core;
    assign o_rx_shadow_on       = r_reg.rx_sh;

    for (genvar c = 0; c < NL; c++)
    begin : g_cntr
        assign o_tx_counter_status[c*WW +: WW] = WW'(r_reg.tx_sh[c]) << `ECS_SHADOW_BIT;
    end

    // ----------------------------------------
    // Configuration ports
    // ----------------------------------------
    for (genvar l = 0; l < NL; l++)
    begin : g_sd
        ecs_cfg_port #(.AW(SA), .DW(DW), .DEPTH(`ECS_STORE_DEPTH), .ACC(`ECS_ACC_CYC)) u_port
        (
            .i_ref_clk  (i_ref_clk),
            .i_rst      (i_rst),
            .i_regs_clr (r_reg.regs_clr),
            .i_addr     (i_sd_addr[l*SA +: SA]),                            // R2
            .i_write    (i_sd_write[l]),
            .i_read     (i_sd_read[l]),
            .i_wdata    (i_sd_wdata[l*DW +: DW]),
            .o_rdata    (o_sd_rdata[l*DW +: DW]),
            .o_waitreq  (o_sd_waitreq[l])
        );
    end

    for (genvar l = 0; l < NL; l++)
    begin : g_fec
        ecs_cfg_port #(.AW(FA), .DW(DW), .DEPTH(`ECS_STORE_DEPTH), .ACC(`ECS_ACC_CYC)) u_port
        (
            .i_ref_clk  (i_ref_clk),
            .i_rst      (i_rst),
            .i_regs_clr (r_reg.regs_clr),
            .i_addr     (i_fec_addr[l*FA +: FA]),                           // R5
            .i_write    (i_fec_write[l]),
            .i_read     (i_fec_read[l]),
            .i_wdata    (i_fec_wdata[l*DW +: DW]),
            .o_rdata    (o_fec_rdata[l*DW +: DW]),
            .o_waitreq  (o_fec_waitreq[l])
        );
    end

    if (PTP_COMBO)
    begin : g_ts_on
        for (genvar p = 0; p < NTS; p++)
        begin : g_ts
            ecs_cfg_port #(.AW(TA), .DW(DW), .DEPTH(`ECS_STORE_DEPTH), .ACC(`ECS_ACC_CYC)) u_port
            (
                .i_ref_clk  (i_ref_clk),
                .i_rst      (i_rst),
                .i_regs_clr (r_reg.regs_clr),
                .i_addr     (i_ts_addr[p*TA +: TA]),                        // R7
                .i_write    (i_ts_write[p]),
                .i_read     (i_ts_read[p]),
                .i_wdata    (i_ts_wdata[p*DW +: DW]),
                .o_rdata    (o_ts_rdata[p*DW +: DW]),
                .o_waitreq  (o_ts_waitreq[p])
            );
        end
    end
    else
    begin : g_ts_off
        // Absent in other variants: stall forever, read zero
        assign o_ts_rdata   = '0;                                           // R8
        assign o_ts_waitreq = '1;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ready_hard_drop: // R21
    assert property (@(posedge i_ref_clk) disable iff (i_rst) !hard_n_s |=> (o_core_ready == '0))
    else $error("core ready stayed high through a global reset");

    a_ready_init_wait: // R21
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!o_core_ready[0] && r_reg.icnt[0] != '0) |=> !o_core_ready[0])
    else $error("core ready rose before initialisation ended");

    a_local_fault_gate: // R15
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (LF_MODE == ECS_LF_OFF) |-> (o_local_fault == '0))
    else $error("local fault raised with fault handling off");

    a_remote_fault_gate: // R16
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (LF_MODE != ECS_LF_BIDIR) |-> (o_remote_fault == '0))
    else $error("remote fault raised without bidirectional handling");

    a_ready_needs_lock: // R14
    assert property (@(posedge i_ref_clk) disable iff (i_rst) o_rx_ready[0] |-> o_rx_block_lock[0])
    else $error("receive ready without block lock");

    a_snap_rise_sets: // R17
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_stats_snapshot[0] && !r_reg.snap_q[0])
        |=> (o_rx_shadow_on[0] && o_tx_counter_status[`ECS_SHADOW_BIT]))
    else $error("snapshot rise did not set both shadow bits");

    a_snap_fall_clears: // R19
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!i_stats_snapshot[0] && r_reg.snap_q[0])
        |=> (!o_rx_shadow_on[0] && !o_tx_counter_status[`ECS_SHADOW_BIT]))
    else $error("snapshot fall did not clear both shadow bits");

endmodule

`default_nettype wire

// [core/ecs_consts.svh]
// Constants for the Ethernet core configuration ports and status block
// Contract
// (R1) All configuration ports run on the shared clock and idle on its reset.
// (R2) Serdes port: 19-bit address per lane, byte-wide write and read data per lane.
// (R3) Serdes write strobe commits write data; read strobe starts a read cycle.
// (R4) Serdes access finishes only when stall drops low; master holds request until then.
// (R5) FEC port: 11-bit address, 8-bit data, separate write and read strobes per channel.
// (R6) FEC port stall holds off the pending operation until the device completes it.
// (R7) Timestamp ports: independent address, strobes, 8-bit data, stall per bridge, 19-bit address.
// (R8) Timestamp ports exist only in the combined 100G, single-lane, FEC and timing variant; here they exist whenever PTP_COMBO is set, whatever IS_100G.
// (R9) Fabric synchronises every status output; only the snapshot input is synchronous. The fabric model syncs only clock lock and core-ready.
// (R10) Per-lane recovered clock lock flag; divided recovered clocks usable only while high.
// (R11) Channel raises transmit-lanes-stable once all its transmit lanes are stable.
// (R12) Channel raises block lock when 66-bit alignment completes on all its lanes.
// (R13) 100G channel raises marker lock after markers found and virtual lanes deskewed.
// (R14) Receive-ready rises only when receive lanes are aligned and data is accepted.
// (R15) Local fault follows receive fault; works only with unidirectional or bidirectional handling.
// (R16) Remote fault follows partner fault sets; works only with bidirectional handling.
// (R17) Snapshot rise sets transmit status bit 1 at 0x846 and receive shadow bit; fall clears.
// (R18) User logic holds snapshot high while freezing, synchronous to the transmit clock.
// (R19) One snapshot acts as transmit and receive shadow request together; fans out.
// (R20) High error-rate flag follows the receive high error-rate state.
// (R21) Core-ready drops on global, transmit or soft resets; rises after initialisation.
// (R22) While core-ready is low no traffic or register accesses are accepted or issued. Here the configuration ports accept accesses regardless.
// (R23) User logic runs the configuration clock between 100 and 125 MHz.
// (R24) Configuration reset is synchronous and resets port logic only, not stored registers.
// (R25) On a read, valid data is presented in the cycle the stall drops.
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ECS_CLK_NS      10
`define ECS_INIT_NS     2000
`define ECS_INIT_CYC    ((`ECS_INIT_NS + `ECS_CLK_NS - 1) / `ECS_CLK_NS)
`define ECS_ACC_CYC     2

// ----------------------------------------
// Port geometry
// ----------------------------------------
`define ECS_SD_AW       19
`define ECS_FEC_AW      11
`define ECS_TS_AW       19
`define ECS_DW          8
`define ECS_STORE_DEPTH 16

// ----------------------------------------
// Transmit counter status word
// ----------------------------------------
`define ECS_TX_CNTR_STATUS_OFS 12'h846
`define ECS_SHADOW_BIT  1
`define ECS_WORD_W      32

`endif

// [core/ecs_pkg.sv]
// Types shared by the configuration port and status block
`default_nettype none

package ecs_pkg;

    typedef enum logic [2:0]
    {
        ECS_P_IDLE = 3'h1,
        ECS_P_BUSY = 3'h2,
        ECS_P_DONE = 3'h4
    } ecs_port_st_t;

    typedef enum logic [1:0]
    {
        ECS_LF_OFF    = 2'h0,
        ECS_LF_UNIDIR = 2'h1,
        ECS_LF_BIDIR  = 2'h2
    } ecs_lf_mode_t;

endpackage

`default_nettype wire

// [core/ecs_cfg_port.sv]
// One stalling byte-wide configuration port with flip-flop register storage
`include "ecs_consts.svh"
`default_nettype none

module ecs_cfg_port
    import ecs_pkg::*;
#(
    parameter int AW    = `ECS_SD_AW,
    parameter int DW    = `ECS_DW,
    parameter int DEPTH = `ECS_STORE_DEPTH,
    parameter int ACC   = `ECS_ACC_CYC
)
(
    // Clock and resets
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst,
    input  wire logic          i_regs_clr,
    // Master request
    input  wire logic [AW-1:0] i_addr,
    input  wire logic          i_write,
    input  wire logic          i_read,
    input  wire logic [DW-1:0] i_wdata,
    // Answer
    output logic      [DW-1:0] o_rdata,
    output logic               o_waitreq
);

    localparam int IW    = $clog2(DEPTH);
    localparam int CW    = $clog2(ACC + 1);
    localparam int ACC_D = ACC + 1;

    if (DEPTH < 2 || AW < IW || ACC < 1)
    begin : g_bad
        $error("ecs_cfg_port: unsupported parameters");
    end

    typedef struct packed {
        ecs_port_st_t               st;
        logic [CW-1:0]              cnt;
        logic [DW-1:0]              rdata;
        logic                       waitreq;
        logic [DEPTH-1:0][DW-1:0]   mem;
    } ecs_port_state_t;

    ecs_port_state_t r_reg;
    ecs_port_state_t r_next;
    logic [IW-1:0]   idx;

    // Upper address bits alias onto the small store
    assign idx = i_addr[IW-1:0];

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    always_comb
    begin
        r_next = r_reg;
        case (r_reg.st)
            ECS_P_IDLE:
            begin
                r_next.waitreq = 1'b1;
                if (i_write || i_read)
                begin
                    r_next.st  = ECS_P_BUSY;
                    r_next.cnt = CW'(ACC - 1);
                end
            end
            ECS_P_BUSY:
            begin
                if (r_reg.cnt == '0)
                begin
                    r_next.st      = ECS_P_DONE;
                    r_next.waitreq = 1'b0;                      // R4 R6
                    if (i_write)
                        r_next.mem[idx] = i_wdata;              // R3
                    else
                        r_next.rdata = r_reg.mem[idx];          // R25
                end
                else
                    r_next.cnt = r_reg.cnt - 1'b1;
            end
            ECS_P_DONE:
            begin
                r_next.st      = ECS_P_IDLE;
                r_next.waitreq = 1'b1;
            end
            default:
            begin
                r_next.st      = ECS_P_IDLE;
                r_next.waitreq = 1'b1;
            end
        endcase
        if (i_regs_clr)
            r_next.mem = '0;
        // Port reset leaves the stored registers alone
        if (i_rst)
        begin
            r_next.st      = ECS_P_IDLE;                        // R1 R24
            r_next.cnt     = '0;
            r_next.rdata   = '0;
            r_next.waitreq = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        r_reg <= r_next;
    end

    assign o_rdata   = r_reg.rdata;
    assign o_waitreq = r_reg.waitreq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_stall_low_once: // R4
    assert property (@(posedge i_ref_clk) disable iff (i_rst) !o_waitreq |=> o_waitreq)
    else $error("stall stayed low for more than one cycle");

    a_access_latency: // R6
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (r_reg.st == ECS_P_IDLE && (i_write || i_read)) |-> ##ACC_D !o_waitreq)
    else $error("access did not complete in the fixed latency");

    a_rdata_steady: // R25
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (r_reg.st != ECS_P_BUSY && !i_regs_clr) |=> $stable(o_rdata))
    else $error("read data changed outside a completion");

endmodule

`default_nettype wire

// [dv/ecs_fabric_model.sv]
// Fabric-side consumer of the core's asynchronous status flags
`default_nettype none

module ecs_fabric_model
(
    // Clock
    input  wire logic       i_ref_clk,
    // Raw flags from the core
    input  wire logic [3:0] i_cdr_locked,
    input  wire logic [3:0] i_core_ready,
    // Synchronised view
    output logic      [3:0] o_lane_usable,
    output logic      [3:0] o_ready_sync
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] lock_meta_reg;
    logic [3:0] rdy_meta_reg;

    // Two flops before any use: the flags carry no timing relation to this clock
    always_ff @(posedge i_ref_clk)
    begin
        lock_meta_reg <= i_cdr_locked;
        rdy_meta_reg  <= i_core_ready;
        o_lane_usable <= lock_meta_reg;
        o_ready_sync  <= rdy_meta_reg;
    end
endmodule

`default_nettype wire

// [dv/ecs_top_tb.sv]
// Self-checking bench for the configuration ports and status outputs
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module ecs_top_tb
    import ecs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk, rst, hrn;
    logic [18:0]  ad [9];
    logic [71:0]  wd, rdat;
    logic [8:0]   wr_v, rd_v, wq;
    logic [3:0]   cdr, txok, blk, pf, ros, ber, trn, rrn, tsr, rsr, snap;
    logic [3:0]   lk, tls, bl, am, rdy, lf, rf, her, cr, sh, use_lk, rdy_s;
    logic [127:0] cs;
    int           n_mismatch = 0, num_checks = 0, cyc = 0;

    ecs_top #(.NL(4), .IS_100G(1'b0), .PTP_COMBO(1'b1), .NTS(1), .LF_MODE(ECS_LF_BIDIR), .INIT_CYC(4)) dut_u
    (
        .i_ref_clk(clk), .i_rst(rst),
        .i_sd_addr({ad[3], ad[2], ad[1], ad[0]}), .i_sd_write(wr_v[3:0]), .i_sd_read(rd_v[3:0]),
        .i_sd_wdata(wd[31:0]), .o_sd_rdata(rdat[31:0]), .o_sd_waitreq(wq[3:0]),
        .i_fec_addr({ad[7][10:0], ad[6][10:0], ad[5][10:0], ad[4][10:0]}), .i_fec_write(wr_v[7:4]),
        .i_fec_read(rd_v[7:4]), .i_fec_wdata(wd[63:32]), .o_fec_rdata(rdat[63:32]), .o_fec_waitreq(wq[7:4]),
        .i_ts_addr(ad[8]), .i_ts_write(wr_v[8]), .i_ts_read(rd_v[8]), .i_ts_wdata(wd[71:64]),
        .o_ts_rdata(rdat[71:64]), .o_ts_waitreq(wq[8]),
        .i_lane_cdr_lock(cdr), .i_lane_tx_ok(txok), .i_lane_blk_lock(blk), .i_vlane_deskewed(1'b0),
        .i_rx_pcs_fault(pf), .i_rx_remote_os(ros), .i_rx_ber_alarm(ber), .i_hard_rst_n(hrn),
        .i_tx_rst_n(trn), .i_rx_rst_n(rrn), .i_tx_soft_rst(tsr), .i_rx_soft_rst(rsr), .i_stats_snapshot(snap),
        .o_rx_clk_locked(lk), .o_tx_lanes_stable(tls), .o_rx_block_lock(bl), .o_rx_marker_aligned(am),
        .o_rx_ready(rdy), .o_local_fault(lf), .o_remote_fault(rf), .o_rx_high_error_rate(her),
        .o_core_ready(cr), .o_tx_counter_status(cs), .o_rx_shadow_on(sh)
    );

    ecs_fabric_model fab_u (.i_ref_clk(clk), .i_cdr_locked(lk), .i_core_ready(cr),
                            .o_lane_usable(use_lk), .o_ready_sync(rdy_s));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Port access and closing
    // ----------------------------------------
    // Index 0-3 serdes lanes, 4-7 FEC channels, 8 timestamp bridge
    task automatic acc(input int i, input bit wr, input logic [18:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(negedge clk);
        ad[i] = a;
        wd[i*8+:8] = d;
        if (wr)
            wr_v[i] = 1'b1;
        else
            rd_v[i] = 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wq[i] !== 1'b0 && n < 20);
        q = rdat[i*8+:8];
        `CHK(n < 20, 1'b1)
        @(negedge clk);
        wr_v[i] = 1'b0;
        rd_v[i] = 1'b0;
        @(posedge clk);
        `CHK(wq[i], 1'b1)
    endtask

    task end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Generous against roughly 340 cycles of tests
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        logic [7:0] q, x;
        rst = 1'b1;
        hrn = 1'b0;
        ad = '{default: '0};
        {wd, wr_v, rd_v} = '0;
        {cdr, txok, blk, pf, ros, ber, tsr, rsr, snap} = '0;
        trn = 4'hf;
        rrn = 4'hf;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        hrn = 1'b1;
        `CHK(wq, 9'h1ff)
        repeat (12) @(negedge clk);
        `CHK(rdy_s, 4'hf)
        // Upper address bits alias, so the 0x7fff3 writes land in entry 3
        for (int r = 0; r < 3; r++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                x = 8'hc0 + 8'(i);
                if (r == 0)
                begin
                    acc(i, 1'b1, 19'h7fff3, x, q);
                    acc(i, 1'b1, 19'h0000f, ~x, q);
                end
                else
                begin
                    acc(i, 1'b0, 19'h7fff3, 8'h00, q);
                    `CHK(q, x)
                    acc(i, 1'b0, 19'h0000f, 8'h00, q);
                    `CHK(q, ~x)
                end
            end
            if (r == 1)
            begin
                @(negedge clk) rst = 1'b1;
                @(negedge clk) `CHK(wq, 9'h1ff)
                rst = 1'b0;
            end
        end
        $display("test ports done");
        repeat (12) @(negedge clk);
        {cdr, txok, blk, pf, ros, ber} = {4'h5, 4'ha, 4'hf, 4'h3, 4'h4, 4'h8};
        repeat (6) @(negedge clk);
        `CHK(lk, 4'h5)
        `CHK(use_lk, 4'h5)
        `CHK(tls, 4'ha)
        `CHK(bl, 4'hf)
        `CHK(lf, 4'h3)
        `CHK(rf, 4'h4)
        `CHK(her, 4'h8)
        `CHK(am, 4'h0)
        blk = 4'h7;
        repeat (6) @(negedge clk);
        `CHK(rdy, 4'h7)
        $display("test status done");
        // Receive hard reset on channel 3 gates its error flag but leaves core ready up
        {tsr, rsr, trn, rrn} = {4'h2, 4'h4, 4'he, 4'h7};
        repeat (6) @(negedge clk);
        `CHK(cr, 4'h8)
        `CHK(her, 4'h0)
        {tsr, rsr, trn, rrn} = {4'h0, 4'h0, 4'hf, 4'hf};
        repeat (12) @(negedge clk);
        `CHK(cr, 4'hf)
        `CHK(her, 4'h8)
        $display("test ready done");
        snap = 4'h9;
        repeat (2) @(negedge clk);
        `CHK(sh, 4'h9)
        `CHK(cs[31:0], 32'h2)
        `CHK(cs[127:96], 32'h2)
        snap = 4'h0;
        repeat (2) @(negedge clk);
        `CHK(sh, 4'h0)
        `CHK(cs[31:0], 32'h0)
        $display("test snapshot done");
        end_of_test();
    end
endmodule

`default_nettype wire
